// ---- ee_defs.svh ----
`ifndef EE_DEFS_SVH
`define EE_DEFS_SVH

// Instruction bytes
`define OP_LATCH_ARM 8'h06
`define OP_LATCH_CLEAR 8'h04
`define OP_STATUS_FETCH 8'h05
`define OP_STATUS_STORE 8'h01
`define OP_CLASS_HIGH 4'h0
`define OP_READ_LOW 3'h3
`define OP_WRITE_LOW 3'h2
`define OP_TOP_ADDR_POS 3

// Status byte layout and reset value
`define ST_RESET 8'h30
`define ST_DOG_MSB 5
`define ST_DOG_LSB 4
`define ST_LOCK_MSB 3
`define ST_LOCK_LSB 2
`define DOG_RESET 2'h3
`define LOCK_RESET 2'h0

// Lock range boundaries
`define LOCK_QUARTER_BASE 9'h180
`define LOCK_HALF_BASE 9'h100

// Internal write cycle time and core clock rate
`define WR_CYCLE_US 5000
`define CLK_MHZ 250

`endif

// ---- ee_pkg.sv ----
`include "ee_defs.svh"

package ee_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [8:0] addr_t;
  typedef logic [1:0] period_t;
  typedef logic [3:0] page_idx_t;
  typedef logic [15:0] page_mask_t;
  // Decoded instruction, one-hot
  typedef enum logic [6:0] {
    cmd_none = 7'h01,
    latch_arm_cmd = 7'h02,
    latch_clear_cmd = 7'h04,
    status_fetch_cmd = 7'h08,
    status_store_cmd = 7'h10,
    array_read_cmd = 7'h20,
    array_write_cmd = 7'h40
  } cmd_t;
endpackage

// ---- spi_eeprom_asserts.sv ----
module spi_eeprom_asserts #(
  parameter int unsigned WRITE_CYCLES = 50
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic so_out,
  input wire logic so_oe,
  input wire ee_pkg::period_t dog_period,
  input wire logic busy_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  import ee_pkg::*;
  logic [31:0] busy_len_ff;

  // Length of the running busy stretch, cleared while idle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) busy_len_ff <= 32'h0;
    else if (busy_flag) busy_len_ff <= busy_len_ff + 32'h1;
    else busy_len_ff <= 32'h0;
  end

  a_deselect_quiet: assert property (@(posedge clock) disable iff (reset)
    cs_n && $past(cs_n) |-> !so_oe && !so_out) else $error("serial out active while deselected");
  a_out_on_fall: assert property (@(posedge clock) disable iff (reset)
    !cs_n && $past(!cs_n) && $changed(so_out) |-> !sck) else $error("serial out moved on rise");
  a_oe_rise_frame: assert property (@(posedge clock) disable iff (reset)
    $rose(so_oe) |-> !cs_n && !sck) else $error("output enable rose outside a frame");
  a_busy_span: assert property (@(posedge clock) disable iff (reset)
    $fell(busy_flag) |-> busy_len_ff == WRITE_CYCLES) else $error("busy length wrong");
  a_start_after_rise: assert property (@(posedge clock) disable iff (reset)
    $rose(busy_flag) |-> $past(cs_n) && cs_n) else $error("write started inside a frame");
  a_store_starts_busy: assert property (@(posedge clock) disable iff (reset)
    $changed(dog_period) |-> ##[0:3] busy_flag) else $error("status store without busy");
  a_dog_hold_busy: assert property (@(posedge clock) disable iff (reset)
    busy_flag && $past(busy_flag) |-> $stable(dog_period)) else $error("period moved while busy");
  a_wp_gate: assert property (@(posedge clock) disable iff (reset)
    $rose(busy_flag) |-> $past(wp_n, 4)) else $error("write started with protect pin low");
endmodule

bind spi_eeprom_protect_interface spi_eeprom_asserts #(.WRITE_CYCLES(WRITE_CYCLES))
  spi_eeprom_asserts_i (.clock(clock), .reset(reset), .sck(sck), .cs_n(cs_n), .si(si),
  .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .dog_period(dog_period), .busy_flag(busy_flag));

// ---- spi_eeprom_protect_interface.sv ----
// Contract
// - Opcode, address and data bytes travel most significant bit first.
// - Input sampled on rising serial clock, output changed on falling edges.
// - Serial clock may pause anywhere; transfer resumes where it stopped.
// - Opcode 06 sets the write latch, opcode 04 clears it.
// - Opcode 05 reads status, opcode 01 writes period and lock bits.
// - Opcodes ending 011 read, 010 write; bit 3 is the ninth address bit.
// - Latch clears at reset, after a finished write, and while protect pin low.
// - Latch set, latch clear and status read need only the opcode byte.
// - Status: period bits 5:4, lock bits 3:2, latch 1, busy 0; reset 30h.
// - Busy bit is read-only, one while the internal write runs.
// - Latch bit is a read-only mirror of the write-enable latch.
// - Lock bits 00 none, 01 180-1ff, 10 100-1ff, 11 whole array.
// - Locked locations read normally but never accept writes.
// - Period bits pick the watchdog timeout; 11 disables it, factory value.
// - Status read shifts the status byte out, allowed even while busy.
// - Status write needs the latch set in an earlier, separate frame.
// - Writes need latch set and protect pin high; locked areas never.
// - Array read streams bytes, address increments, wraps 1ff to 000.
// - Page write takes up to 16 bytes, wrapping inside the page.
// - Array write ignored unless the latch was set in a prior frame.
// - Write starts only if chip select rises right after a whole byte.
// - Protect pin low during the frame aborts it; running cycle unaffected.
// - No instruction accepted before a falling chip select after reset.
// - Serial output is high impedance whenever chip select is high.
`include "ee_defs.svh"

module spi_eeprom_protect_interface #(
  parameter int unsigned WRITE_CYCLES = `WR_CYCLE_US * `CLK_MHZ
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so_out,
  output logic so_oe,
  output ee_pkg::period_t dog_period,
  output logic busy_flag
);
  import ee_pkg::*;

  // Link side state, serial clock domain
  logic frame_rst, byte_end, first_edge;
  logic [2:0] bit_idx_ff;
  logic [1:0] byte_idx_ff;
  logic [6:0] shift_ff, out_sh_ff;
  byte_t in_byte, op_ff, st_data_ff;
  cmd_t op_cmd, in_cmd, frame_cmd;
  addr_t addr_ff, rd_addr_ff;
  logic st_ok_ff, end_ok_ff, seq_tgl_ff, rd_tgl_ff, rd_sel_ff, load_ff;
  page_mask_t mask_ff;
  page_idx_t wr_lo_ff;
  byte_t page_buf [16];
  logic so_out_ff, so_oe_ff, arm_s1_ff, arm_s2_ff;

  // Core side state
  logic cs_s1_ff, cs_s2_ff, cs_d_ff, wp_s1_ff, wp_s2_ff;
  logic rq_s1_ff, rq_s2_ff, rq_d_ff, seen_fall_ff, wp_drop_ff, seq_seen_ff;
  logic latch_flag_ff, busy_flag_ff;
  logic [20:0] busy_cnt_ff;
  period_t dog_ff;
  logic [1:0] lock_ff;
  byte_t rd_byte_ff, status_byte;
  byte_t mem [512];
  logic cs_rise, cs_fall, take, write_ok, do_store, do_write, busy_done;

  // Opcode decode shared by both domains
  function automatic cmd_t decode(input byte_t op);
    cmd_t c;
    c = cmd_none;
    if (op == `OP_LATCH_ARM) begin
      c = latch_arm_cmd;
    end else if (op == `OP_LATCH_CLEAR) begin
      c = latch_clear_cmd;
    end else if (op == `OP_STATUS_FETCH) begin
      c = status_fetch_cmd;
    end else if (op == `OP_STATUS_STORE) begin
      c = status_store_cmd;
    end else if (op[7:4] == `OP_CLASS_HIGH && op[2:0] == `OP_READ_LOW) begin
      c = array_read_cmd;
    end else if (op[7:4] == `OP_CLASS_HIGH && op[2:0] == `OP_WRITE_LOW) begin
      c = array_write_cmd;
    end
    return c;
  endfunction

  // Lock range check on a page base
  function automatic logic locked(input addr_t a, input logic [1:0] lk);
    logic hit;
    hit = 1'b0;
    case (lk)
      2'h0: hit = 1'b0;
      2'h1: hit = (a >= `LOCK_QUARTER_BASE);
      2'h2: hit = (a >= `LOCK_HALF_BASE);
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction

  // Chip select high holds the framing counters clear
  assign frame_rst = reset | cs_n;
  assign in_byte = {shift_ff, si};
  assign byte_end = (bit_idx_ff == 3'h7);
  assign first_edge = (bit_idx_ff == 3'h0) && (byte_idx_ff == 2'h0);
  assign op_cmd = decode(op_ff);
  assign in_cmd = decode(in_byte);

  // Bit and byte position; counters only move on real edges
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_idx_ff <= 3'h0;
      byte_idx_ff <= 2'h0;
    end else begin
      bit_idx_ff <= bit_idx_ff + 3'h1;
      if (byte_end && byte_idx_ff != 2'h2) begin
        byte_idx_ff <= byte_idx_ff + 2'h1;
      end
    end
  end

  // Input shifter, rising edge sampling
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      shift_ff <= 7'h00;
    end else begin
      shift_ff <= in_byte[6:0];
    end
  end

  // Frame record; survives the chip select rise so the core can judge it
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      op_ff <= 8'h00;
      addr_ff <= 9'h000;
      st_data_ff <= 8'h00;
      st_ok_ff <= 1'b0;
      end_ok_ff <= 1'b0;
      mask_ff <= 16'h0000;
      wr_lo_ff <= 4'h0;
      seq_tgl_ff <= 1'b0;
    end else begin
      end_ok_ff <= byte_end;
      if (first_edge) begin
        op_ff <= 8'h00;
        st_ok_ff <= 1'b0;
        mask_ff <= 16'h0000;
        seq_tgl_ff <= ~seq_tgl_ff;
      end
      if (byte_end) begin
        case (byte_idx_ff)
          2'h0: begin
            op_ff <= in_byte;
          end
          2'h1: begin
            addr_ff <= {op_ff[`OP_TOP_ADDR_POS], in_byte};
            wr_lo_ff <= in_byte[3:0];
            st_data_ff <= in_byte;
            st_ok_ff <= 1'b1;
          end
          default: begin
            if (op_cmd == array_write_cmd) begin
              mask_ff[wr_lo_ff] <= 1'b1;
              wr_lo_ff <= wr_lo_ff + 4'h1;
            end
          end
        endcase
      end
    end
  end

  // Page buffer; later bytes overwrite earlier ones at the same slot
  always_ff @(posedge sck) begin
    if (byte_end && byte_idx_ff == 2'h2 && op_cmd == array_write_cmd) begin
      page_buf[wr_lo_ff] <= in_byte;
    end
  end

  // Read requests toward the core, one toggle per output byte
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      rd_tgl_ff <= 1'b0;
      rd_sel_ff <= 1'b0;
      rd_addr_ff <= 9'h000;
    end else if (byte_end) begin
      if (byte_idx_ff == 2'h0 && in_cmd == status_fetch_cmd) begin
        rd_sel_ff <= 1'b1;
        rd_tgl_ff <= ~rd_tgl_ff;
      end else if (byte_idx_ff != 2'h0 && op_cmd == status_fetch_cmd) begin
        rd_tgl_ff <= ~rd_tgl_ff;
      end else if (byte_idx_ff == 2'h1 && op_cmd == array_read_cmd) begin
        rd_sel_ff <= 1'b0;
        rd_addr_ff <= {op_ff[`OP_TOP_ADDR_POS], in_byte};
        rd_tgl_ff <= ~rd_tgl_ff;
      end else if (byte_idx_ff == 2'h2 && op_cmd == array_read_cmd) begin
        rd_addr_ff <= rd_addr_ff + 9'h001;
        rd_tgl_ff <= ~rd_tgl_ff;
      end
    end
  end

  // Marks the falling edge that must load a fresh output byte
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      load_ff <= 1'b0;
    end else begin
      load_ff <= byte_end && (
        (byte_idx_ff == 2'h0 && in_cmd == status_fetch_cmd) ||
        (byte_idx_ff != 2'h0 && op_cmd == status_fetch_cmd) ||
        (byte_idx_ff != 2'h0 && op_cmd == array_read_cmd));
    end
  end

  // Armed flag into the link domain, level crossing
  always_ff @(negedge sck or posedge reset) begin
    if (reset) begin
      arm_s1_ff <= 1'b0;
      arm_s2_ff <= 1'b0;
    end else begin
      arm_s1_ff <= seen_fall_ff;
      arm_s2_ff <= arm_s1_ff;
    end
  end

  // Output shifter on falling edges; high impedance while deselected
  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      out_sh_ff <= 7'h00;
      so_out_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else if (load_ff) begin
      so_out_ff <= rd_byte_ff[7];
      out_sh_ff <= rd_byte_ff[6:0];
      so_oe_ff <= arm_s2_ff;
    end else begin
      so_out_ff <= out_sh_ff[6];
      out_sh_ff <= {out_sh_ff[5:0], 1'b0};
    end
  end

  assign so_out = so_out_ff;
  assign so_oe = so_oe_ff;

  // Pin synchronisers into the core clock
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_d_ff <= 1'b1;
      wp_s1_ff <= 1'b0;
      wp_s2_ff <= 1'b0;
    end else begin
      cs_s1_ff <= cs_n;
      cs_s2_ff <= cs_s1_ff;
      cs_d_ff <= cs_s2_ff;
      wp_s1_ff <= wp_n;
      wp_s2_ff <= wp_s1_ff;
    end
  end

  // Read request toggle crossing
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rq_s1_ff <= 1'b0;
      rq_s2_ff <= 1'b0;
      rq_d_ff <= 1'b0;
    end else begin
      rq_s1_ff <= rd_tgl_ff;
      rq_s2_ff <= rq_s1_ff;
      rq_d_ff <= rq_s2_ff;
    end
  end

  assign cs_rise = cs_s2_ff & ~cs_d_ff;
  assign cs_fall = ~cs_s2_ff & cs_d_ff;

  // Nothing is accepted until chip select has fallen once
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      seen_fall_ff <= 1'b0;
    end else if (cs_fall) begin
      seen_fall_ff <= 1'b1;
    end
  end

  // Protect pin dropping inside a frame spoils that frame
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wp_drop_ff <= 1'b0;
    end else if (!cs_s2_ff && !wp_s2_ff) begin
      wp_drop_ff <= 1'b1;
    end else if (cs_fall) begin
      wp_drop_ff <= 1'b0;
    end
  end

  // Frame record is quiet once the synchronised rise is seen
  assign frame_cmd = decode(op_ff);
  assign take = cs_rise & seen_fall_ff & (seq_tgl_ff != seq_seen_ff);
  assign write_ok = latch_flag_ff & wp_s2_ff & ~wp_drop_ff & ~busy_flag_ff & end_ok_ff;
  assign do_store = take && frame_cmd == status_store_cmd && write_ok && st_ok_ff;
  assign do_write = take && frame_cmd == array_write_cmd && write_ok &&
                    mask_ff != 16'h0000 && !locked({addr_ff[8:4], 4'h0}, lock_ff);
  assign busy_done = busy_flag_ff && busy_cnt_ff == 21'h000000;

  // A clockless frame must not replay the previous one
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      seq_seen_ff <= 1'b0;
    end else if (cs_rise) begin
      seq_seen_ff <= seq_tgl_ff;
    end
  end

  // Write-enable latch; protect pin low overrides any set, a set beats the write end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      latch_flag_ff <= 1'b0;
    end else if (!wp_s2_ff) begin
      latch_flag_ff <= 1'b0;
    end else if (take && frame_cmd == latch_arm_cmd) begin
      latch_flag_ff <= 1'b1;
    end else if (busy_done) begin
      latch_flag_ff <= 1'b0;
    end else if (take && frame_cmd == latch_clear_cmd) begin
      latch_flag_ff <= 1'b0;
    end
  end

  // Internal write cycle modelled as a down counter
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busy_flag_ff <= 1'b0;
      busy_cnt_ff <= 21'h000000;
    end else if (do_store || do_write) begin
      busy_flag_ff <= 1'b1;
      busy_cnt_ff <= 21'(WRITE_CYCLES - 1);
    end else if (busy_done) begin
      busy_flag_ff <= 1'b0;
    end else if (busy_flag_ff) begin
      busy_cnt_ff <= busy_cnt_ff - 21'h000001;
    end
  end

  // Nonvolatile control bits of the status byte
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dog_ff <= `DOG_RESET;
      lock_ff <= `LOCK_RESET;
    end else if (do_store) begin
      dog_ff <= st_data_ff[`ST_DOG_MSB:`ST_DOG_LSB];
      lock_ff <= st_data_ff[`ST_LOCK_MSB:`ST_LOCK_LSB];
    end
  end

  // Status image; top two bits fixed at zero
  assign status_byte = {2'h0, dog_ff, lock_ff, latch_flag_ff, busy_flag_ff};

  // Array update at the start of the cycle; only captured slots land
  always_ff @(posedge clock) begin
    if (do_write) begin
      for (int i = 0; i < 16; i++) begin
        if (mask_ff[i]) begin
          mem[{addr_ff[8:4], 4'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // Read answers; reads ignore locks and busy state
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_byte_ff <= `ST_RESET;
    end else if (rq_s2_ff != rq_d_ff) begin
      if (rd_sel_ff) begin
        rd_byte_ff <= status_byte;
      end else begin
        rd_byte_ff <= mem[rd_addr_ff];
      end
    end
  end

  // Watchdog period and busy go out from registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dog_period <= `DOG_RESET;
      busy_flag <= 1'b0;
    end else begin
      dog_period <= dog_ff;
      busy_flag <= busy_flag_ff;
    end
  end

endmodule

// ---- spi_eeprom_protect_interface_tb.sv ----
module spi_eeprom_protect_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ee_pkg::*;
  localparam int unsigned WCYC = 800;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic wp_n = 1'b1;
  logic sck, cs_n, si, so_out, so_oe, busy_flag;
  period_t dog_period;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  byte_t exp_q[$];
  byte_t mem[512];
  byte_t st = 8'h30;
  byte_t d[$];
  addr_t probe[3] = '{9'h050, 9'h140, 9'h1c0};

  spi_eeprom_protect_interface #(.WRITE_CYCLES(WCYC)) spi_eeprom_protect_interface_i (
    .clock(clock), .reset(reset), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .so_out(so_out), .so_oe(so_oe), .dog_period(dog_period), .busy_flag(busy_flag));
  spi_host_model spi_host_model_i (.sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe(so_oe));

  initial begin
    forever #2 clock = ~clock;
  end

  task automatic end_sim();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Hang guard sized well above the expected run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input string what, input byte_t exp, input byte_t got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Each reported byte is matched against the oldest expectation
  initial begin
    forever begin
      @(spi_host_model_i.rx_ev);
      if (exp_q.size() == 0) chk("spare byte", 8'h00, 8'hff);
      else chk("read byte", exp_q.pop_front(), spi_host_model_i.rx_byte);
    end
  end

  task automatic xf(input byte_t tx[$], input int nbits, input int keep);
    spi_host_model_i.run(tx, nbits, keep);
  endtask

  task automatic st_rd(input byte_t exp);
    exp_q.push_back(exp);
    xf('{8'h05}, 16, 1);
  endtask

  task automatic idle();
    for (int i = 0; i < 1000 && busy_flag; i++) @(posedge clock);
  endtask

  function automatic bit locked(input addr_t a);
    return st[3:2] == 2'h3 || (st[3] && a[8]) || (st[3:2] == 2'h1 && a[8:7] == 2'h3);
  endfunction

  // Arm in its own frame, then write; the model keeps what should land
  task automatic wr(input addr_t a, input byte_t dd[$], input int nbits, input bit allow,
                    input bit wt);
    byte_t tx[$];
    bit ok;
    tx = dd;
    tx.push_front(a[7:0]);
    tx.push_front({4'h0, a[8], 3'h2});
    ok = allow && nbits % 8 == 0 && nbits >= 24 && !locked(a);
    xf('{8'h06}, 8, 99);
    xf(tx, nbits, 99);
    if (ok) foreach (dd[i]) mem[{a[8:4], a[3:0] + i[3:0]}] = dd[i];
    st[1] = allow && !ok;
    repeat (20) @(posedge clock);
    chk("busy", {7'h0, ok}, {7'h0, busy_flag});
    if (wt) idle();
  endtask

  initial begin
    void'($urandom(32'h5879));
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    repeat (10) @(posedge clock);
    chk("period", 8'h03, {6'h0, dog_period});
    st_rd(8'h30);
    xf('{8'h06}, 8, 99);
    st_rd(8'h32);
    xf('{8'h04}, 8, 99);
    st_rd(8'h30);
    xf('{8'h01, 8'h0c}, 16, 99);
    st_rd(8'h30);
    xf('{8'h06}, 8, 99);
    wp_n <= 1'b0;
    repeat (8) @(posedge clock);
    wp_n <= 1'b1;
    st_rd(8'h30);
    // Page overfilled by two bytes, then a two-byte write ending at the top address
    for (int i = 0; i < 18; i++) d.push_back(byte_t'($urandom));
    wr(9'h000, d, 160, 1, 1);
    d = d[0:1];
    spi_host_model_i.slow = 1'b1;
    wr(9'h1fe, d, 32, 1, 0);
    st_rd(8'h33);
    idle();
    st_rd(8'h30);
    spi_host_model_i.slow = 1'b0;
    // Aborted writes: mid-byte rise, no data byte, protect pin dropped mid-frame
    wr(9'h001, d, 35, 1, 1);
    st_rd(8'h32);
    wr(9'h002, d, 16, 1, 1);
    fork
      wr(9'h005, d, 32, 0, 1);
      begin
        repeat (700) @(posedge clock);
        wp_n <= 1'b0;
        repeat (8) @(posedge clock);
        wp_n <= 1'b1;
      end
    join
    for (int i = 0; i < 18; i++) exp_q.push_back(mem[addr_t'(9'h1fe + i)]);
    xf('{8'h0b, 8'hfe}, 160, 2);
    // Every lock range and period code, probing three regions each time
    for (int l = 0; l < 4; l++) begin
      xf('{8'h06}, 8, 99);
      xf('{8'h01, {2'h3, 2'(l), 2'(l), 2'h3}}, 16, 99);
      st = {2'h0, 2'(l), 2'(l), 2'h0};
      repeat (20) @(posedge clock);
      chk("period", {6'h0, 2'(l)}, {6'h0, dog_period});
      idle();
      st_rd(st);
      foreach (probe[j]) begin
        d = '{byte_t'($urandom)};
        wr(probe[j], d, 24, 1, 1);
        exp_q.push_back(mem[probe[j]]);
        xf('{{4'h0, probe[j][8], 3'h3}, probe[j][7:0]}, 24, 2);
      end
    end
    repeat (10) @(posedge clock);
    chk("pending reads", 8'h00, byte_t'(exp_q.size()));
    end_sim();
  end
endmodule

// ---- spi_host_model.sv ----
module spi_host_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import ee_pkg::*;
  logic so_last_ff = 1'b0;
  logic slow = 1'b0;
  ee_pkg::byte_t rx_byte;
  event rx_ev;
  // Released line shows the inverse of its last value, never a stale copy
  wire logic so_wire = so_oe ? so_out : ~so_last_ff;

  always @(posedge sck) begin
    if (so_oe) so_last_ff <= so_out;
  end

  // Link idles with clock low and device deselected
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // One frame of nbits clocks; filler is random; bytes from index keep are reported
  task automatic run(input byte_t tx[$], input int nbits, input int keep);
    byte_t sh;
    #1 cs_n = 1'b0;
    for (int k = 0; k < nbits; k++) begin
      if (k % 8 == 0) sh = (k / 8 < tx.size()) ? tx[k / 8] : byte_t'($urandom);
      si = sh[7 - k % 8];
      #80 sck = 1'b1;
      rx_byte = {rx_byte[6:0], so_wire};
      if (k % 8 == 7 && k / 8 >= keep) ->rx_ev;
      #80 sck = 1'b0;
      if (slow && k % 5 == 2) #($urandom_range(8, 1) * 4);
    end
    #80 cs_n = 1'b1;
    si = ~si;
    #200;
  endtask
endmodule
